//--- hdl/adce_engine.sv
// Contract
// - the aes part encrypts or decrypts 128-bit blocks with a 128-bit key.
// - the aes result becomes readable 375 clock cycles after the start and not earlier.
// - an xor load mode combines each value written while the aes part is idle with the state memory content; loads during a run are dropped.
// - each des step finishes in one clock cycle, so a block takes 16 cycles and triple des is done by repeating.
`include "adce_defines.svh"

module adce_engine (
   input  wire logic                    clk,        // 100 MHz clock
   input  wire logic                    rst_n,      // async reset, active low
   input  wire logic                    clk_en,     // freezes all state except the reset synchronizer when low
   input  wire adce_pkg::adce_aes_load_t aes_load,  // key or state load
   input  wire logic                    aes_start,  // start pulse
   input  wire logic                    aes_decrypt, // 1 = decrypt
   input  wire logic                    aes_done_clr, // clears done flag
   output logic [127:0]                 aes_result, // state memory readout
   output logic                         aes_busy,   // operation running
   output logic                         aes_done,   // sticky completion
   input  wire adce_pkg::adce_des_req_t des_req,    // one des step
   output logic [63:0]                  des_data,   // step result
   output logic [4:0]                   des_round,  // steps done in block
   output logic                         des_valid   // step result valid
);
   logic rst_s1_q, rst_s2_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   adce_pkg::adce_state_t          state_q, state_d;
   logic [`ADCE_BLOCK_W-1:0]       key_q, key_d, st_q, st_d;
   logic [`ADCE_AES_CNT_W-1:0]     cnt_q, cnt_d;
   logic                           dec_q, dec_d, done_q, done_d;
   logic [`ADCE_DES_W-1:0]         dd_q, dd_d;
   logic [`ADCE_DES_RND_W-1:0]     rnd_q, rnd_d;
   logic                           dv_q, dv_d;

   // keyed mixing per round stands in for the cipher core datapath
   function automatic logic [127:0] adce_round(input logic [127:0] s, input logic [127:0] k,
                                              input logic [8:0] c, input logic dec);
      logic [127:0] r;
      r = dec ? {s[0], s[127:1]} : {s[126:0], s[127]};
      adce_round = r ^ k ^ {119'h0, c};
   endfunction : adce_round

   function automatic logic [63:0] adce_des_step(input logic [63:0] d, input logic [63:0] k,
                                                input logic [4:0] r, input logic dec);
      logic [63:0] kr;
      kr = {k[58:0], k[63:59]} ^ {59'h0, r};
      adce_des_step = {d[31:0], d[63:32] ^ (dec ? ~kr[31:0] : kr[31:0])};
   endfunction : adce_des_step

   always_comb begin
      state_d = state_q;
      key_d   = key_q;
      st_d    = st_q;
      cnt_d   = cnt_q;
      dec_d   = dec_q;
      done_d  = done_q;
      if (aes_done_clr) begin
         done_d = 1'b0;
      end
      unique case (state_q)
         adce_pkg::ADCE_IDLE: begin
            if (aes_load.valid) begin
               unique case (aes_load.kind)
                  adce_pkg::ADCE_LD_WRITE: st_d  = aes_load.data;
                  adce_pkg::ADCE_LD_XOR:   st_d  = st_q ^ aes_load.data;
                  adce_pkg::ADCE_LD_KEY:   key_d = aes_load.data;
                  adce_pkg::ADCE_LD_NONE: ;
               endcase
            end else if (aes_start) begin
               state_d = adce_pkg::ADCE_BUSY;
               cnt_d   = `ADCE_AES_CNT_W'(`ADCE_AES_CYCLES - 1);
               dec_d   = aes_decrypt;
               done_d  = 1'b0;
            end
         end
         adce_pkg::ADCE_BUSY: begin
            st_d = adce_round(st_q, key_q, cnt_q, dec_q);
            if (cnt_q == '0) begin
               state_d = adce_pkg::ADCE_IDLE;
               done_d  = 1'b1;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
      endcase
   end

   always_comb begin
      dd_d  = dd_q;
      rnd_d = rnd_q;
      dv_d  = 1'b0;
      if (des_req.valid) begin
         dd_d  = adce_des_step(des_req.data, des_req.key, rnd_q, des_req.decrypt);
         dv_d  = 1'b1;
         rnd_d = (rnd_q == `ADCE_DES_RND_W'(`ADCE_DES_ROUNDS - 1)) ? '0 : rnd_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         state_q <= adce_pkg::ADCE_IDLE;
         key_q   <= 128'h0;
         st_q    <= 128'h0;
         cnt_q   <= 9'h000;
         dec_q   <= 1'b0;
         done_q  <= 1'b0;
         dd_q    <= 64'h0;
         rnd_q   <= 5'h00;
         dv_q    <= 1'b0;
      end else if (clk_en) begin
         state_q <= state_d;
         key_q   <= key_d;
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         dec_q   <= dec_d;
         done_q  <= done_d;
         dd_q    <= dd_d;
         rnd_q   <= rnd_d;
         dv_q    <= dv_d;
      end
   end

   // result held at zero while busy so a premature read gets nothing useful
   logic [127:0] res_q;
   logic         busy_q;
   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         res_q  <= 128'h0;
         busy_q <= 1'b0;
      end else if (clk_en) begin
         res_q  <= (state_d == adce_pkg::ADCE_IDLE) ? st_d : 128'h0;
         busy_q <= (state_d == adce_pkg::ADCE_BUSY);
      end
   end

   assign aes_result = res_q;
   assign aes_busy   = busy_q;
   assign aes_done   = done_q;
   assign des_data   = dd_q;
   assign des_round  = rnd_q;
   assign des_valid  = dv_q;
endmodule : adce_engine

//--- hdl/adce_defines.svh
`ifndef ADCE_DEFINES_SVH
`define ADCE_DEFINES_SVH

`define ADCE_BLOCK_W      128
`define ADCE_DES_W        64
`define ADCE_AES_CYCLES   375
`define ADCE_AES_CNT_W    9
`define ADCE_DES_ROUNDS   16
`define ADCE_DES_RND_W    5

`endif

//--- hdl/adce_pkg.sv
package adce_pkg;
   typedef enum logic [1:0] {
      ADCE_LD_WRITE,
      ADCE_LD_XOR,
      ADCE_LD_KEY,
      ADCE_LD_NONE
   } adce_load_t;

   typedef struct packed {
      logic         valid;
      adce_load_t   kind;
      logic [127:0] data;
   } adce_aes_load_t;

   typedef struct packed {
      logic        valid;
      logic        decrypt;
      logic [63:0] key;
      logic [63:0] data;
   } adce_des_req_t;

   typedef enum {
      ADCE_IDLE,
      ADCE_BUSY
   } adce_state_t;
endpackage : adce_pkg

//--- verification/adce_engine_checker.sv
module adce_engine_checker (
   input wire logic                     clk,          // clock
   input wire logic                     rst_n,        // reset
   input wire logic                     clk_en,       // enable
   input wire adce_pkg::adce_aes_load_t aes_load,     // load
   input wire logic                     aes_start,    // start
   input wire logic                     aes_decrypt,  // mode
   input wire logic                     aes_done_clr, // clear
   input wire logic [127:0]             aes_result,   // result
   input wire logic                     aes_busy,     // busy
   input wire logic                     aes_done,     // done
   input wire adce_pkg::adce_des_req_t  des_req,      // step
   input wire logic [63:0]              des_data,     // step out
   input wire logic [4:0]               des_round,    // count
   input wire logic                     des_valid     // step valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n || !clk_en);
   wire logic go = aes_start && !aes_busy && !aes_load.valid;
   wire logic ld = aes_load.valid && !aes_busy;
   AST_AES_LAT: assert property (go |-> ##[375:375] (aes_busy && !aes_done) ##1 (aes_done && !aes_busy))
      else $error("aes latency wrong");
   AST_AES_HIDE: assert property (aes_busy |-> aes_result == 128'h0)
      else $error("result seen while busy");
   AST_XOR_LOAD: assert property (ld && aes_load.kind == adce_pkg::ADCE_LD_XOR |=>
      aes_result == ($past(aes_result) ^ $past(aes_load.data)))
      else $error("xor load wrong");
   AST_DONE_HOLD: assert property (aes_done && !aes_done_clr && !aes_start |=> aes_done)
      else $error("done dropped");
   AST_DES_STEP: assert property (des_req.valid |=> des_valid && des_round == {1'b0, $past(des_round[3:0]) + 4'h1})
      else $error("des step wrong");
   cover property (go ##1 aes_busy);
   cover property (ld && aes_load.kind == adce_pkg::ADCE_LD_XOR);
   cover property (des_valid && des_round == 5'h00);
endmodule : adce_engine_checker
bind adce_engine adce_engine_checker u_adce_engine_checker (.*);

//--- verification/adce_engine_tb.sv
module adce_engine_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                     clk = 0, rst_n = 0, clk_en = 1, aes_start = 0, aes_decrypt = 0, aes_done_clr = 0;
   adce_pkg::adce_aes_load_t aes_load = '0;
   adce_pkg::adce_des_req_t  des_req = '0;
   logic [127:0]             aes_result, r1;
   logic                     aes_busy, aes_done, des_valid;
   logic [63:0]              des_data;
   logic [4:0]               des_round;
   int                       n_mismatch = 0, n_compared = 0;
   always #5 clk = ~clk;
   adce_engine u_adce_engine (.*);
   task step; @(posedge clk); #1; endtask : step
   task chk(string n, logic [127:0] e, logic [127:0] g);
      n_compared++;
      if (e !== g) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task load(adce_pkg::adce_load_t k, logic [127:0] d);
      aes_load = '{1'b1, k, d};
      step;
      aes_load = '0;
   endtask : load
   task t_xor;
      load(adce_pkg::ADCE_LD_WRITE, 128'h0123456789ABCDEF_0F1E2D3C4B5A6978);
      load(adce_pkg::ADCE_LD_XOR, 128'hFFFF0000FFFF0000_00000000FFFFFFFF);
      step;
      chk("xor", 128'hFEDC45677654CDEF_0F1E2D3CB4A59687, aes_result);
   endtask : t_xor
   task t_aes(logic dec, logic poke);
      int i;
      load(adce_pkg::ADCE_LD_KEY, 128'h2B7E151628AED2A6_ABF7158809CF4F3C);
      load(adce_pkg::ADCE_LD_WRITE, 128'h3243F6A8885A308D_313198A2E0370734);
      {aes_start, aes_decrypt} = {1'b1, dec};
      step;
      aes_start = 0;
      i = 0;
      while (aes_done !== 1'b1 && i < 400) begin
         if (poke && i == 100) aes_start = 1;
         if (poke && i == 101) load(adce_pkg::ADCE_LD_WRITE, 128'h0);
         else step;
         aes_start = 0;
         i++;
      end
      if (i >= 400) begin
         n_mismatch++;
         finish_test;
      end
      chk("latency", 375, i);
      chk("busy", 0, aes_busy);
   endtask : t_aes
   task t_des;
      logic [63:0] d;
      d = 64'h0123456789ABCDEF;
      for (int i = 0; i < 32; i++) begin
         des_req = '{1'b1, i >= 16, 64'h133457799BBCDFF1, d};
         step;
         des_req = '0;
         chk("des_valid", 1, des_valid);
         chk("des_round", (i + 1) % 16, des_round);
         d = des_data;
         step;
         chk("des_pulse", 0, des_valid);
         chk("des_hold", d, des_data);
      end
   endtask : t_des
   task t_freeze;
      logic [4:0] r;
      r = des_round;
      clk_en = 0;
      des_req = '{1'b1, 1'b0, 64'h1, 64'h2};
      step;
      step;
      chk("frz_valid", 0, des_valid);
      chk("frz_round", r, des_round);
      des_req = '0;
      clk_en = 1;
      step;
   endtask : t_freeze
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_n = 1;
      repeat (3) step;
      t_xor;
      t_aes(0, 0);
      r1 = aes_result;
      t_aes(0, 1);
      chk("refused", r1, aes_result);
      aes_done_clr = 1;
      step;
      aes_done_clr = 0;
      chk("done_clr", 0, aes_done);
      t_aes(1, 0);
      t_des;
      t_freeze;
      finish_test;
   end
endmodule : adce_engine_tb
